// File: src/tds_pkg.sv
// Purpose: shared constants of the target detection and status register bank
// Assumes: register indices are word indices, byte address is four times the index
// Notes:   bits marked not used read as zero
package tds_pkg;

  // register indices
  localparam logic [5:0] IDX_LOW_FIELD  = 6'h16;
  localparam logic [5:0] IDX_ID_BYTES   = 6'h17;
  localparam logic [5:0] IDX_DETECT     = 6'h18;
  localparam logic [5:0] IDX_PROTOCOL   = 6'h19;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h20;
  localparam logic [5:0] IDX_IRQ_MASK   = 6'h21;

  // reset values
  localparam logic [7:0] LOW_FIELD_RST  = 8'h00;
  localparam logic [7:0] DETECT_RST     = 8'h00;
  localparam logic [7:0] PROTOCOL_RST   = 8'h00;
  localparam logic [7:0] IRQ_RST        = 8'h00;

  // writable bits
  localparam logic [7:0] LOW_FIELD_WMASK = 8'h87;
  localparam logic [7:0] DETECT_WMASK    = 8'hEF;
  localparam logic [7:0] IRQ_BITS        = 8'h4C;

  // low field level fields
  localparam int LF_CLKX_DIS_BIT = 7;
  localparam int LF_COLL_LSB     = 0;
  localparam int LF_COLL_MSB     = 2;

  // detection level fields
  localparam int DL_SIZE_MSB  = 7;
  localparam int DL_SIZE_LSB  = 6;
  localparam int DL_AUTO_BIT  = 5;
  localparam int DL_EXT_BIT   = 3;
  localparam int DL_WAKE_MSB  = 2;
  localparam int DL_WAKE_LSB  = 0;

  // protocol status fields
  localparam int PS_WAKE_BIT  = 7;
  localparam int PS_COLL_BIT  = 6;
  localparam int PS_ALT_BIT   = 4;
  localparam int PS_SENS_BIT  = 3;
  localparam int PS_TYPEB_BIT = 2;
  localparam int PS_RATE_MSB  = 1;
  localparam int PS_CLR_MSB   = 4;

  // interrupt status bits
  localparam int IRQ_FIELD_BIT = 2;
  localparam int IRQ_ACOLL_BIT = 3;
  localparam int IRQ_RX_BIT    = 6;

  // identifier size codes and lengths
  localparam logic [1:0] SIZE_4      = 2'h0;
  localparam logic [1:0] SIZE_7      = 2'h1;
  localparam logic [1:0] SIZE_10     = 2'h2;
  localparam logic [1:0] SIZE_BAD    = 2'h3;
  localparam logic [3:0] LEN_4       = 4'h4;
  localparam logic [3:0] LEN_7       = 4'h7;
  localparam logic [3:0] LEN_10      = 4'hA;
  localparam int         ID_MAX      = 10;

  // bit rate codes
  localparam logic [1:0] RATE_RSVD = 2'h0;
  localparam logic [1:0] RATE_106  = 2'h1;
  localparam logic [1:0] RATE_212  = 2'h2;
  localparam logic [1:0] RATE_424  = 2'h3;

endpackage

// File: src/tds_anticoll.sv
// Purpose: identifier store and automatic anticollision answer engine
// Assumes: identifier bytes arrive one per write, in order
// Notes:   a forbidden size code never starts the engine
`timescale 1ns/1ps
module tds_anticoll
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // identifier load
  input  wire logic       id_wr,
  input  wire logic [7:0] id_wdata,
  input  wire logic       id_restart,
  // configuration
  input  wire logic [1:0] size_code,
  input  wire logic       auto_en,
  // request and answer
  input  wire logic       start_req,
  input  wire logic       tx_ready,
  output logic            tx_valid,
  output logic [7:0]      tx_data,
  output logic            busy,
  output logic            done
);

  typedef enum logic [1:0] {
    TDS_IDLE   = 2'b00,
    TDS_SEND   = 2'b01,
    TDS_FINISH = 2'b10
  } tds_state_t;

  tds_state_t state_reg;
  logic [7:0] id_mem [tds_pkg::ID_MAX];
  logic [3:0] wr_ptr_reg;
  logic [3:0] rd_ptr_reg;
  logic [3:0] id_len;
  logic       advance;
  logic       last_byte;

  // selected identifier length
  always_comb
  begin
    case (size_code)
      tds_pkg::SIZE_4:  id_len = tds_pkg::LEN_4;
      tds_pkg::SIZE_7:  id_len = tds_pkg::LEN_7;
      tds_pkg::SIZE_10: id_len = tds_pkg::LEN_10;
      default:          id_len = 4'h0;
    endcase
  end

  assign advance   = (state_reg == TDS_SEND) && tx_ready;
  assign last_byte = (rd_ptr_reg == id_len - 4'h1);
  assign tx_valid  = (state_reg == TDS_SEND);
  assign busy      = (state_reg != TDS_IDLE);
  assign done      = (state_reg == TDS_FINISH);

  // extra bytes beyond the selected length are dropped so the store stays intact
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wr_ptr_reg <= 4'h0;
    else if (id_restart)
      wr_ptr_reg <= 4'h0;
    else if (id_wr && (wr_ptr_reg < id_len))
      wr_ptr_reg <= wr_ptr_reg + 4'h1;
  end

  always_ff @(posedge clk)
  begin
    if (id_wr && (wr_ptr_reg < id_len))
      id_mem[wr_ptr_reg] <= id_wdata;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg  <= TDS_IDLE;
      rd_ptr_reg <= 4'h0;
      tx_data    <= 8'h00;
    end
    else
    begin
      case (state_reg)
        TDS_IDLE:
        begin
          if (start_req && auto_en && (size_code != tds_pkg::SIZE_BAD))
          begin
            state_reg  <= TDS_SEND;
            rd_ptr_reg <= 4'h0;
            tx_data    <= id_mem[0];
          end
        end
        TDS_SEND:
        begin
          if (advance && last_byte)
            state_reg <= TDS_FINISH;
          else if (advance)
          begin
            rd_ptr_reg <= rd_ptr_reg + 4'h1;
            tx_data    <= id_mem[rd_ptr_reg + 4'h1];
          end
        end
        TDS_FINISH:
          state_reg <= TDS_IDLE;
        default:
          state_reg <= TDS_IDLE;
      endcase
    end
  end

  // helper count of bytes sent in one answer
  logic [3:0] sent_cnt;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sent_cnt <= 4'h0;
    else if (state_reg == TDS_IDLE)
      sent_cnt <= 4'h0;
    else if (advance)
      sent_cnt <= sent_cnt + 4'h1;
  end

  id_length_a: assert property (@(posedge clk) disable iff (!rst_n)
    done |-> (sent_cnt == id_len))
    else $error("anticollision answer length differs from size code");

  auto_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(busy) |-> $past(auto_en) && $past(start_req))
    else $error("anticollision started without enable and request");

endmodule

// File: src/tds_target_detect.sv
// Purpose: target detection levels, identifier load and first command status over APB
// Assumes: comparator pins are asynchronous; decoder strobes are on pclk
// Notes:   pready is always high, so every access ends in its first access cycle
`timescale 1ns/1ps
// How it works
// - top bit of low field register switches the carrier clock extractor off.
// - low field level bits set collision threshold; comparator shows on status bit 6.
// - size code selects 4, 7 or 10 identifier bytes; code 11 is forbidden.
// - auto enable bit lets the internal engine answer anticollision with stored identifier.
// - wake-up level bits set wake threshold; all zero turns wake detection off.
// - detection bit 3 selects the extended RF measurement range.
// - detection level register survives full power-down on the always-on supply.
// - status bit 6 follows the collision comparator live, bit 7 the wake comparator only while wake detection is on; never latched.
// - status bits 4 to 0 clear after the host reads the register.
// - status bits 1:0 give first command bit rate: 01, 10, 11.
// - status bit 4 set for the alternative coding, clear for Type A.
// - status bit 3 set when the first command was a sense or all request.
// - status bit 2 set when the first reader command was Type B.
// - field detection raises the interrupt with status value 04.
// - finished automatic anticollision raises the interrupt with status value 08.
// - received frame raises status 40; protocol reads C9 or C5 then.
// - Type B request without auto anticollision stays for the host to answer.
module tds_target_detect
#(
  parameter int ADDR_W = 8
)
(
  // apb slave
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // always-on supply reset
  input  wire logic              vin_rst_n,
  // comparator pins
  input  wire logic              above_wakeup_level_pin,
  input  wire logic              above_collision_level_pin,
  // analog front end controls
  output logic                   clock_extractor_off,
  output logic      [2:0]        collision_level_sel,
  output logic      [2:0]        wakeup_level_sel,
  output logic                   wakeup_detect_on,
  output logic                   extended_rf_range,
  // first command decoder
  input  wire logic              first_cmd_valid,
  input  wire logic [1:0]        first_cmd_rate,
  input  wire logic              alt_coding_flag,
  input  wire logic              sens_req_seen,
  input  wire logic              type_b_detected,
  input  wire logic              field_detect,
  input  wire logic              frame_done,
  // anticollision answer
  output logic                   acoll_tx_valid,
  output logic      [7:0]        acoll_tx_data,
  input  wire logic              acoll_tx_ready,
  output logic                   acoll_busy,
  // interrupt
  output logic                   irq
);

  if (ADDR_W < 8)
  begin : g_addr_check
    $error("ADDR_W must be at least 8");
  end

  function automatic logic hits(input logic [ADDR_W-1:0] addr, input logic [5:0] idx);
    hits = (addr == ADDR_W'({idx, 2'b00}));
  endfunction

  logic [7:0] low_field_reg;
  logic [7:0] detect_reg;
  logic [4:0] proto_lo_reg;
  logic       cmd_new_reg;
  logic [7:0] irq_status_reg;
  logic [7:0] irq_mask_reg;
  logic [7:0] rd_byte;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  logic        mapped;
  logic        setup;
  logic        access;
  logic        wr_en;
  logic        rd_en;
  logic        capture;
  logic        proto_rd_clr;
  logic        acoll_done;
  logic [2:0]  wake_sync;
  logic [2:0]  coll_sync;
  logic        wake_filt_reg;
  logic        coll_filt_reg;
  logic        wake_bit;
  logic [7:0]  proto_byte;
  logic        cap_late_reg;

  // bus phases
  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign wr_en  = access && pwrite;
  assign rd_en  = access && !pwrite;
  assign pready = 1'b1;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg && access;

  assign mapped = hits(paddr, tds_pkg::IDX_LOW_FIELD) || hits(paddr, tds_pkg::IDX_ID_BYTES) ||
                  hits(paddr, tds_pkg::IDX_DETECT) || hits(paddr, tds_pkg::IDX_PROTOCOL) ||
                  hits(paddr, tds_pkg::IDX_IRQ_STATUS) || hits(paddr, tds_pkg::IDX_IRQ_MASK);

  // comparator pins: three stages, a change counts when the last two agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wake_sync     <= 3'h0;
      coll_sync     <= 3'h0;
      wake_filt_reg <= 1'b0;
      coll_filt_reg <= 1'b0;
    end
    else
    begin
      wake_sync <= {wake_sync[1:0], above_wakeup_level_pin};
      coll_sync <= {coll_sync[1:0], above_collision_level_pin};
      if (wake_sync[1] == wake_sync[2])
        wake_filt_reg <= wake_sync[2];
      if (coll_sync[1] == coll_sync[2])
        coll_filt_reg <= coll_sync[2];
    end
  end

  // wake comparator is ignored while its level is zero, since detection is off then
  assign wake_bit   = wake_filt_reg && wakeup_detect_on;
  assign proto_byte = {wake_bit, coll_filt_reg, 1'b0, proto_lo_reg};

  // low field level register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      low_field_reg <= tds_pkg::LOW_FIELD_RST;
    else if (wr_en && hits(paddr, tds_pkg::IDX_LOW_FIELD))
      low_field_reg <= pwdata[7:0] & tds_pkg::LOW_FIELD_WMASK;
  end

  assign clock_extractor_off = low_field_reg[tds_pkg::LF_CLKX_DIS_BIT];
  assign collision_level_sel = low_field_reg[tds_pkg::LF_COLL_MSB:tds_pkg::LF_COLL_LSB];

  // detection level register lives on the always-on reset, apart from presetn
  always_ff @(posedge pclk or negedge vin_rst_n)
  begin
    if (!vin_rst_n)
      detect_reg <= tds_pkg::DETECT_RST;
    else if (wr_en && hits(paddr, tds_pkg::IDX_DETECT))
      detect_reg <= pwdata[7:0] & tds_pkg::DETECT_WMASK;
  end

  assign wakeup_level_sel  = detect_reg[tds_pkg::DL_WAKE_MSB:tds_pkg::DL_WAKE_LSB];
  assign wakeup_detect_on  = (wakeup_level_sel != 3'h0);
  assign extended_rf_range = detect_reg[tds_pkg::DL_EXT_BIT];

  // first command status: only the first command after a read is kept
  assign capture      = first_cmd_valid && !cmd_new_reg;
  assign proto_rd_clr = rd_en && hits(paddr, tds_pkg::IDX_PROTOCOL);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      proto_lo_reg <= tds_pkg::PROTOCOL_RST[tds_pkg::PS_CLR_MSB:0];
      cmd_new_reg  <= 1'b0;
    end
    else if (capture)
    begin
      // a capture in the read cycle wins over the clear
      proto_lo_reg <= {alt_coding_flag, sens_req_seen,
                       type_b_detected, first_cmd_rate};
      cmd_new_reg  <= 1'b1;
    end
    else if (proto_rd_clr && !cap_late_reg)
    begin
      proto_lo_reg <= 5'h00;
      cmd_new_reg  <= 1'b0;
    end
  end

  // zero wait states: a capture at the setup edge missed the returned byte, so keep it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cap_late_reg <= 1'b0;
    else
      cap_late_reg <= capture;
  end

  // identifier load and anticollision engine
  tds_anticoll u_anticoll
  (
    .clk        (pclk),
    .rst_n      (presetn),
    .id_wr      (wr_en && hits(paddr, tds_pkg::IDX_ID_BYTES)),
    .id_wdata   (pwdata[7:0]),
    .id_restart (wr_en && hits(paddr, tds_pkg::IDX_DETECT)),
    .size_code  (detect_reg[tds_pkg::DL_SIZE_MSB:tds_pkg::DL_SIZE_LSB]),
    .auto_en    (detect_reg[tds_pkg::DL_AUTO_BIT]),
    .start_req  (first_cmd_valid && sens_req_seen),
    .tx_ready   (acoll_tx_ready),
    .tx_valid   (acoll_tx_valid),
    .tx_data    (acoll_tx_data),
    .busy       (acoll_busy),
    .done       (acoll_done)
  );

  // interrupt status: sticky, cleared by a read of the bits that read returned
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_status_reg <= tds_pkg::IRQ_RST;
    else
    begin
      for (int i = 0; i < 8; i++)
      begin
        if ((i == tds_pkg::IRQ_FIELD_BIT && field_detect) ||
            (i == tds_pkg::IRQ_ACOLL_BIT && acoll_done) ||
            (i == tds_pkg::IRQ_RX_BIT && frame_done))
          irq_status_reg[i] <= 1'b1;
        else if (rd_en && hits(paddr, tds_pkg::IDX_IRQ_STATUS) && prdata_reg[i])
          irq_status_reg[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask_reg <= tds_pkg::IRQ_RST;
    else if (wr_en && hits(paddr, tds_pkg::IDX_IRQ_MASK))
      irq_mask_reg <= pwdata[7:0] & tds_pkg::IRQ_BITS;
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  // read data is sampled in the setup cycle so prdata comes from a flip-flop
  always_comb
  begin
    rd_byte = 8'h00;
    if (hits(paddr, tds_pkg::IDX_LOW_FIELD))
      rd_byte = low_field_reg;
    else if (hits(paddr, tds_pkg::IDX_DETECT))
      rd_byte = detect_reg;
    else if (hits(paddr, tds_pkg::IDX_PROTOCOL))
      rd_byte = proto_byte;
    else if (hits(paddr, tds_pkg::IDX_IRQ_STATUS))
      rd_byte = irq_status_reg;
    else if (hits(paddr, tds_pkg::IDX_IRQ_MASK))
      rd_byte = irq_mask_reg;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
    else if (setup)
    begin
      prdata_reg  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      pslverr_reg <= !mapped;
    end
  end

  // checks
  clkx_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && hits(paddr, tds_pkg::IDX_LOW_FIELD) |=> clock_extractor_off == $past(pwdata[7]))
    else $error("clock extractor control did not follow the write");

  coll_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && hits(paddr, tds_pkg::IDX_PROTOCOL) |=> prdata[6] == $past(coll_filt_reg))
    else $error("collision comparator not shown on status bit 6");

  wake_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wakeup_level_sel == 3'h0) |-> !proto_byte[tds_pkg::PS_WAKE_BIT])
    else $error("wake comparator shown while detection is off");

  ext_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && hits(paddr, tds_pkg::IDX_DETECT) |=> extended_rf_range == $past(pwdata[3]))
    else $error("extended range did not follow the write");

  detect_keep_a: assert property (@(posedge pclk) disable iff (!vin_rst_n)
    !presetn |=> $stable(detect_reg))
    else $error("detection level changed during main reset");

  pin_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(coll_sync[2]) && coll_sync[1] |=> coll_filt_reg)
    else $error("collision comparator not followed");

  read_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    proto_rd_clr && !capture && !cap_late_reg |=> proto_lo_reg == 5'h00)
    else $error("status low bits not cleared by read");

  rate_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    capture |=> proto_lo_reg[tds_pkg::PS_RATE_MSB:0] == $past(first_cmd_rate))
    else $error("first command rate not captured");

  type_b_a: assert property (@(posedge pclk) disable iff (!presetn)
    capture |=> proto_lo_reg[tds_pkg::PS_TYPEB_BIT] == $past(type_b_detected)
                && proto_lo_reg[tds_pkg::PS_ALT_BIT] == $past(alt_coding_flag))
    else $error("coding or type flags not captured");

  sens_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
    capture |=> proto_lo_reg[tds_pkg::PS_SENS_BIT] == $past(sens_req_seen))
    else $error("sense request flag not captured");

  field_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    field_detect |=> irq_status_reg[tds_pkg::IRQ_FIELD_BIT])
    else $error("field detect did not set its status bit");

  status_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && hits(paddr, tds_pkg::IDX_IRQ_STATUS) && !field_detect
    && prdata_reg[tds_pkg::IRQ_FIELD_BIT] |=> !irq_status_reg[tds_pkg::IRQ_FIELD_BIT])
    else $error("status read left the field bit set");

  acoll_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    acoll_done |=> irq_status_reg[tds_pkg::IRQ_ACOLL_BIT])
    else $error("anticollision done did not set its status bit");

  rx_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    frame_done && irq_mask_reg[tds_pkg::IRQ_RX_BIT] |=> irq)
    else $error("frame done did not raise the interrupt");

  bad_size_a: assert property (@(posedge pclk) disable iff (!presetn)
    !acoll_busy && first_cmd_valid && sens_req_seen
    && detect_reg[tds_pkg::DL_SIZE_MSB:tds_pkg::DL_SIZE_LSB] == tds_pkg::SIZE_BAD |=> !acoll_busy)
    else $error("anticollision started with a forbidden size");

  map_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !mapped |=> pslverr)
    else $error("unmapped access gave no error response");

endmodule

// File: test/tds_reader_model.sv
// Purpose: reader side model, decoder strobes, field comparators, answer sink
// Assumes: strobes and ready change just after a rising edge
// Notes:   qualified levels invert outside a pulse so stale values never match
`timescale 1ns/1ps
module tds_reader_model
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // decoder strobes
  output logic            first_cmd_valid,
  output logic [1:0]      first_cmd_rate,
  output logic            alt_coding_flag,
  output logic            sens_req_seen,
  output logic            type_b_detected,
  output logic            field_detect,
  output logic            frame_done,
  // field comparators
  output logic            wake_pin,
  output logic            coll_pin,
  // answer sink
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready
);
  logic [7:0] rx_bytes [0:15];
  int         rx_n;
  logic [2:0] stall_cnt;
  initial
  begin
    {first_cmd_valid, first_cmd_rate, alt_coding_flag, sens_req_seen} = 5'h00;
    {type_b_detected, field_detect, frame_done, wake_pin, coll_pin} = 5'h00;
    tx_ready = 1'b0;
    rx_n = 0;
  end
  // ready drops two cycles of eight so the engine must hold its byte
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      stall_cnt <= 3'h0;
    else
      stall_cnt <= stall_cnt + 3'h1;
  always @(posedge pclk)
  begin
    tx_ready <= (stall_cnt[2:1] != 2'h3);
    if (tx_valid && tx_ready && rx_n < 16)
    begin
      rx_bytes[rx_n] <= tx_data;
      rx_n <= rx_n + 1;
    end
  end
  task automatic clear_rx;
    rx_n = 0;
  endtask
  task automatic set_field(input logic w, input logic c);
    @(posedge pclk);
    wake_pin <= w;
    coll_pin <= c;
  endtask
  // first command of the reader, one cycle strobe
  task automatic send_cmd(input logic [1:0] r, input logic a, s, b);
    @(posedge pclk);
    first_cmd_valid <= 1'b1;
    {first_cmd_rate, alt_coding_flag, sens_req_seen, type_b_detected} <= {r, a, s, b};
    @(posedge pclk);
    first_cmd_valid <= 1'b0;
    {first_cmd_rate, alt_coding_flag, sens_req_seen, type_b_detected} <= ~{r, a, s, b};
  endtask
  task automatic pulse_evt(input logic f, input logic d);
    @(posedge pclk);
    field_detect <= f;
    frame_done <= d;
    @(posedge pclk);
    field_detect <= 1'b0;
    frame_done <= 1'b0;
  endtask
endmodule

// File: test/nfc_target_detect_status_tb.sv
// Purpose: self-checking bench of the target detection register bank
// Assumes: apb master waits for pready under a bounded count
// Notes:   seeded random register values with fixed corner cases
`timescale 1ns/1ps
module nfc_target_detect_status_tb;
  logic        pclk, presetn, vin_rst_n, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr, v, d, txd;
  logic [31:0] pwdata, prdata, r;
  logic        clkx, wk_on, ext, fv, alt, sens, tyb, fd, fr, wp, cp, txv, txr, busy, irq;
  logic [1:0]  rate;
  logic [2:0]  csel, wsel;
  logic [7:0]  id [0:9];
  logic [3:0]  len;
  int          err_total, check_count, seed, i, j, n;

  tds_target_detect DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .vin_rst_n(vin_rst_n), .above_wakeup_level_pin(wp),
    .above_collision_level_pin(cp), .clock_extractor_off(clkx), .collision_level_sel(csel),
    .wakeup_level_sel(wsel), .wakeup_detect_on(wk_on), .extended_rf_range(ext),
    .first_cmd_valid(fv), .first_cmd_rate(rate), .alt_coding_flag(alt),
    .sens_req_seen(sens), .type_b_detected(tyb), .field_detect(fd), .frame_done(fr),
    .acoll_tx_valid(txv), .acoll_tx_data(txd), .acoll_tx_ready(txr), .acoll_busy(busy),
    .irq(irq));
  tds_reader_model rdr (.pclk(pclk), .presetn(presetn), .first_cmd_valid(fv),
    .first_cmd_rate(rate), .alt_coding_flag(alt), .sens_req_seen(sens),
    .type_b_detected(tyb), .field_detect(fd), .frame_done(fr), .wake_pin(wp),
    .coll_pin(cp), .tx_valid(txv), .tx_data(txd), .tx_ready(txr));

  always #2.5 pclk = ~pclk;

  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer; read data and error taken at the pready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
    if (k >= 50)
    begin
      err_total++;
      end_sim;
    end
  endtask
  function automatic logic [31:0] proto(input logic w, c, a, s, b, input logic [1:0] rt);
    return {24'h0, w, c, 1'b0, a, s, b, rt};
  endfunction

  initial
  begin
    {pclk, presetn, vin_rst_n, psel, penable, pwrite} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    seed = 32'h98247628;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    vin_rst_n <= 1'b1;
    apb(0, 8'h58, 0);
    chk("low_field_rst", r, 0);
    apb(0, 8'h64, 0);
    chk("protocol_rst", r, 0);
    apb(0, 8'h00, 0);
    chk("unmapped_err", e, 1);
    chk("unmapped_rd", r, 0);
    for (i = 0; i < 8; i++)
    begin
      v = (i == 0) ? 8'hFF : 8'($random(seed));
      d = (i == 0) ? 8'h08 : 8'($random(seed)) & 8'hDF;
      apb(1, 8'h58, {24'h0, v});
      apb(0, 8'h58, 0);
      chk("low_field", r, v & 8'h87);
      chk("clk_extract_off", clkx, v[7]);
      chk("coll_sel", csel, v[2:0]);
      apb(1, 8'h60, {24'h0, d});
      apb(0, 8'h60, 0);
      chk("detect", r, d & 8'hEF);
      chk("wake_sel", wsel, d[2:0]);
      chk("wake_on", wk_on, d[2:0] != 3'h0);
      chk("ext_range", ext, d[3]);
    end
    apb(1, 8'h60, 32'hCB);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 8'h60, 0);
    chk("detect_kept", r, 32'hCB);
    apb(0, 8'h58, 0);
    chk("low_field_cleared", r, 0);
    rdr.set_field(1, 1);
    repeat (6) @(posedge pclk);
    apb(0, 8'h64, 0);
    chk("comparators_hi", r, 32'hC0);
    rdr.set_field(0, 1);
    repeat (6) @(posedge pclk);
    apb(0, 8'h64, 0);
    chk("comparators_mix", r, 32'h40);
    rdr.set_field(0, 0);
    repeat (6) @(posedge pclk);
    apb(1, 8'h84, 32'h4C);
    for (i = 0; i < 4; i++)
    begin
      v = 8'($random(seed));
      rdr.send_cmd(i[1:0], v[0], v[1], v[2]);
      rdr.send_cmd(~i[1:0], ~v[0], ~v[1], ~v[2]);
      apb(0, 8'h64, 0);
      chk("first_cmd", r, proto(0, 0, v[0], v[1], v[2], i[1:0]));
      apb(0, 8'h64, 0);
      chk("read_clear", r, 0);
    end
    rdr.pulse_evt(1, 0);
    repeat (2) @(posedge pclk);
    chk("irq_field", irq, 1);
    apb(0, 8'h80, 0);
    chk("status_field", r, 32'h04);
    chk("irq_cleared", irq, 0);
    apb(1, 8'h84, 0);
    rdr.pulse_evt(0, 1);
    repeat (2) @(posedge pclk);
    chk("irq_masked", irq, 0);
    apb(0, 8'h80, 0);
    chk("status_masked", r, 32'h40);
    apb(1, 8'h84, 32'h4C);
    rdr.set_field(1, 1);
    for (i = 0; i < 2; i++)
    begin
      repeat (6) @(posedge pclk);
      rdr.send_cmd(2'h1, 0, i == 0, i == 1);
      rdr.pulse_evt(0, 1);
      repeat (2) @(posedge pclk);
      chk("irq_frame", irq, 1);
      apb(0, 8'h80, 0);
      chk("status_frame", r, 32'h40);
      apb(0, 8'h64, 0);
      chk("proto_frame", r, (i == 0) ? 32'hC9 : 32'hC5);
    end
    rdr.set_field(0, 0);
    for (i = 0; i < 3; i++)
    begin
      len = (i == 0) ? 4'h4 : (i == 1) ? 4'h7 : 4'hA;
      apb(1, 8'h60, {24'h0, i[1:0], 6'h21});
      rdr.clear_rx();
      for (j = 0; j <= len; j++)
      begin
        if (j < 10)
          id[j] = 8'($random(seed));
        apb(1, 8'h5C, {24'h0, id[j % 10]});
      end
      rdr.send_cmd(2'h1, 0, 1, 0);
      // the engine leaves idle only after the edge that samples the request
      @(posedge pclk);
      n = 0;
      while (busy !== 1'b0 && n < 200)
      begin
        @(posedge pclk);
        n++;
      end
      repeat (2) @(posedge pclk);
      chk("acoll_wait", n < 200, 1);
      chk("acoll_len", rdr.rx_n, len);
      for (j = 0; j < len; j++)
        chk("acoll_byte", rdr.rx_bytes[j], id[j]);
      chk("irq_acoll", irq, 1);
      apb(0, 8'h80, 0);
      chk("status_acoll", r, 32'h08);
      apb(0, 8'h64, 0);
    end
    apb(1, 8'h60, 32'hE1);
    rdr.send_cmd(2'h1, 0, 1, 0);
    repeat (2) @(posedge pclk);
    chk("forbidden_size", busy, 0);
    end_sim;
  end
endmodule
